// ---- verilog/hcp_pkg.sv ----
// constants, register map and types for the hall commutation and protection block
// Operation
// R1: hall 101/100/110 drive bottom-first arm pairs
// R2: hall 010/011/001 drive top-first arm pairs
// R3: all-equal hall code: arms off, pulses follow
// R4: triple pulse odd steps, single steps one-three
// R5: pwm compare gates bottom arms only
// R6: current limit blanks bottoms until pwm tick
// R7: overcurrent kills all, recovers after delay
// R8: undervoltage kills all until recover flag
// R9: command zones: off, top only, full
// R10: frozen triple pulse locks, recovers later
// R11: lock times scale with timing capacitor
// R12: no lock detect at low command/faults (code inhibits it on undervoltage and overtemp only)
// R13: overtemp kills all until recover flag
// R14: hall supply on above off level
// R15: hall supply off: halls low, pulses low
// R16: protections ored, override hall decoding
// R17: never both arms of one phase
package hcp_pkg;

    localparam int CLK_MHZ             = 125;
    localparam int PWM_PERIOD_US       = 50;
    localparam int PWM_PERIOD_CYCLES   = PWM_PERIOD_US * CLK_MHZ;
    localparam int OC_RECOVER_US       = 1000;
    localparam int OC_RECOVER_CYCLES   = OC_RECOVER_US * CLK_MHZ;
    localparam int LOCK_DETECT_US      = 2000;
    localparam int LOCK_DETECT_CYCLES  = LOCK_DETECT_US * CLK_MHZ;
    localparam int LOCK_RECOVER_US     = 12000;
    localparam int LOCK_RECOVER_CYCLES = LOCK_RECOVER_US * CLK_MHZ;
    localparam int LOCK_CAP_REF_PF     = 1000;

    localparam int TMR_W = 48;

    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_STATUS   = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c;
    localparam logic [11:0] ADDR_LOCK_CAP = 12'h010;

    localparam int          CTRL_DRIVE_BIT = 0;
    localparam logic        CTRL_DRIVE_RST = 1'b1;
    localparam logic [15:0] LOCK_CAP_RST   = 16'h03e8;
    localparam logic [15:0] LOCK_CAP_MIN   = 16'h0001;

    localparam int EV_CL   = 0;
    localparam int EV_OC   = 1;
    localparam int EV_UV   = 2;
    localparam int EV_OT   = 3;
    localparam int EV_LOCK = 4;
    localparam int EV_W    = 5;
    localparam logic [EV_W-1:0] MASK_RST = 5'h00;

    localparam int ST_STEP_LSB  = 0;
    localparam int ST_FAULT_LSB = 4;
    localparam int ST_HALL_SUP  = 9;
    localparam int ST_SPD_T     = 10;
    localparam int ST_SPD_S     = 11;

    localparam int PIN_HU    = 0;
    localparam int PIN_HV    = 1;
    localparam int PIN_HW    = 2;
    localparam int PIN_CL    = 3;
    localparam int PIN_OC    = 4;
    localparam int PIN_UVT   = 5;
    localparam int PIN_UVR   = 6;
    localparam int PIN_OTT   = 7;
    localparam int PIN_OTR   = 8;
    localparam int PIN_OFF   = 9;
    localparam int PIN_SAW   = 10;
    localparam int PIN_LOCK  = 11;
    localparam int PIN_PWM   = 12;
    localparam int PIN_W     = 13;

    // arm vector order: {w_bot, w_top, v_bot, v_top, u_bot, u_top}
    localparam int ARM_UT = 0;
    localparam int ARM_UB = 1;
    localparam int ARM_VT = 2;
    localparam int ARM_VB = 3;
    localparam int ARM_WT = 4;
    localparam int ARM_WB = 5;
    localparam logic [5:0] ARMS_OFF = 6'h00;
    localparam logic [5:0] ARMS_S1  = 6'h06;
    localparam logic [5:0] ARMS_S2  = 6'h12;
    localparam logic [5:0] ARMS_S3  = 6'h18;
    localparam logic [5:0] ARMS_S4  = 6'h09;
    localparam logic [5:0] ARMS_S5  = 6'h21;
    localparam logic [5:0] ARMS_S6  = 6'h24;
    localparam logic [5:0] TOP_MASK = 6'h15;
    localparam logic [5:0] BOT_MASK = 6'h2a;

    typedef enum logic [2:0] {
        STEP_NONE = 3'b000,
        STEP_1    = 3'b001,
        STEP_2    = 3'b010,
        STEP_3    = 3'b011,
        STEP_4    = 3'b100,
        STEP_5    = 3'b101,
        STEP_6    = 3'b110
    } hcp_step_e;

endpackage

// ---- verilog/hcp_timer_if.sv ----
// carrier between the top and its delay timers
`timescale 1ns/1ps
interface hcp_timer_if
    import hcp_pkg::*;
;
    logic             run;
    logic [TMR_W-1:0] limit;
    logic [TMR_W-1:0] step;
    logic             expired;

    modport timer (input run, input limit, input step, output expired);
    modport user  (output run, output limit, output step, input expired);
endinterface

// ---- verilog/hcp_delay_timer.sv ----
// accumulating delay timer: expires once step-sum reaches limit
`timescale 1ns/1ps
module hcp_delay_timer
    import hcp_pkg::*;
(
    input wire logic   clk,
    input wire logic   reset,
    hcp_timer_if.timer tif
);
    logic [TMR_W-1:0] acc_r;
    logic [TMR_W-1:0] acc_nxt;

    // summing a step instead of dividing keeps capacitor scaling cheap
    always_comb begin
        acc_nxt = acc_r;
        if (!tif.run) begin
            acc_nxt = '0;
        end else if (acc_r < tif.limit) begin
            acc_nxt = acc_r + tif.step;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            acc_r <= '0;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    assign tif.expired = tif.run && (acc_r >= tif.limit);

    a_timer_restart: assert property (@(posedge clk) disable iff (reset)
        !tif.run |=> (acc_r == '0)) else $error("timer did not restart"); // R11
endmodule

// ---- verilog/hcp_commutation_top.sv ----
// hall commutation, pwm gating and protection with apb registers
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module hcp_commutation_top
    import hcp_pkg::*;
#(
    parameter int PWM_PERIOD   = PWM_PERIOD_CYCLES,
    parameter int OC_RECOVER   = OC_RECOVER_CYCLES,
    parameter int LOCK_DETECT  = LOCK_DETECT_CYCLES,
    parameter int LOCK_RECOVER = LOCK_RECOVER_CYCLES
)(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        hall_u_level,
    input  wire logic        hall_v_level,
    input  wire logic        hall_w_level,
    input  wire logic        current_limit_flag,
    input  wire logic        overcurrent_flag,
    input  wire logic        undervoltage_trip_flag,
    input  wire logic        undervoltage_recover_flag,
    input  wire logic        overtemp_trip_flag,
    input  wire logic        overtemp_recover_flag,
    input  wire logic        cmd_above_off,
    input  wire logic        cmd_above_sawtooth_low,
    input  wire logic        cmd_above_lock_level,
    input  wire logic        pwm_compare,
    output logic             phase_u_top,
    output logic             phase_u_bottom,
    output logic             phase_v_top,
    output logic             phase_v_bottom,
    output logic             phase_w_top,
    output logic             phase_w_bottom,
    output logic             speed_pulse_triple,
    output logic             speed_pulse_single,
    output logic             hall_supply_out,
    output logic             irq
);
    localparam int PWM_CW = $clog2(PWM_PERIOD + 1);

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    if (PWM_PERIOD < 2) begin : g_chk_pwm
        $error("pwm period must be at least two cycles");
    end
    if (OC_RECOVER < 1 || LOCK_DETECT < 1 || LOCK_RECOVER < 1) begin : g_chk_tmr
        $error("recovery and lock times must be at least one cycle");
    end

    // every pin flag is asynchronous to clk
    logic [PIN_W-1:0] pins_a;
    logic [PIN_W-1:0] sync1_r;
    logic [PIN_W-1:0] sync2_r;

    assign pins_a = {pwm_compare, cmd_above_lock_level, cmd_above_sawtooth_low, cmd_above_off,
                     overtemp_recover_flag, overtemp_trip_flag, undervoltage_recover_flag,
                     undervoltage_trip_flag, overcurrent_flag, current_limit_flag,
                     hall_w_level, hall_v_level, hall_u_level};

    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pins_a;
            sync2_r <= sync1_r;
        end
    end

    logic [2:0] hall_s;
    logic       cl_s;
    logic       oc_s;
    logic       uv_trip_s;
    logic       uv_ok_s;
    logic       ot_trip_s;
    logic       ot_ok_s;
    logic       cmd_off_s;
    logic       cmd_saw_s;
    logic       cmd_lock_s;
    logic       pwm_s;

    assign hall_s     = {sync2_r[PIN_HU], sync2_r[PIN_HV], sync2_r[PIN_HW]};
    assign cl_s       = sync2_r[PIN_CL];
    assign oc_s       = sync2_r[PIN_OC];
    assign uv_trip_s  = sync2_r[PIN_UVT];
    assign uv_ok_s    = sync2_r[PIN_UVR];
    assign ot_trip_s  = sync2_r[PIN_OTT];
    assign ot_ok_s    = sync2_r[PIN_OTR];
    assign cmd_off_s  = sync2_r[PIN_OFF];
    assign cmd_saw_s  = sync2_r[PIN_SAW];
    assign cmd_lock_s = sync2_r[PIN_LOCK];
    assign pwm_s      = sync2_r[PIN_PWM];

    // {step, single, triple, arms}
    function automatic logic [10:0] hcp_decode(input logic [2:0] h);
        logic [10:0] d;
        d = {STEP_NONE, 1'b0, 1'b0, ARMS_OFF};
        case (h)
            3'b101:  d = {STEP_1, 1'b1, 1'b1, ARMS_S1}; // R1 R4
            3'b100:  d = {STEP_2, 1'b1, 1'b0, ARMS_S2}; // R1 R4
            3'b110:  d = {STEP_3, 1'b1, 1'b1, ARMS_S3}; // R1 R4
            3'b010:  d = {STEP_4, 1'b0, 1'b0, ARMS_S4}; // R2 R4
            3'b011:  d = {STEP_5, 1'b0, 1'b1, ARMS_S5}; // R2 R4
            3'b001:  d = {STEP_6, 1'b0, 1'b0, ARMS_S6}; // R2 R4
            3'b111:  d = {STEP_NONE, 1'b1, 1'b1, ARMS_OFF}; // R3
            default: d = {STEP_NONE, 1'b0, 1'b0, ARMS_OFF}; // R3
        endcase
        return d;
    endfunction

    hcp_timer_if oc_tif();
    hcp_timer_if ldet_tif();
    hcp_timer_if lrec_tif();

    hcp_delay_timer u_oc_timer   (.clk(clk), .reset(reset), .tif(oc_tif));
    hcp_delay_timer u_ldet_timer (.clk(clk), .reset(reset), .tif(ldet_tif));
    hcp_delay_timer u_lrec_timer (.clk(clk), .reset(reset), .tif(lrec_tif));

    logic [5:0]        arms_r,     arms_nxt;
    logic [2:0]        step_r,     step_nxt;
    logic              triple_r,   triple_nxt;
    logic              single_r,   single_nxt;
    logic              hall_sup_r, hall_sup_nxt;
    logic              cl_latch_r, cl_latch_nxt;
    logic              oc_r,       oc_nxt;
    logic              uv_r,       uv_nxt;
    logic              ot_r,       ot_nxt;
    logic              lock_r,     lock_nxt;
    logic [PWM_CW-1:0] pwm_cnt_r,  pwm_cnt_nxt;
    logic              pwm_tick;
    logic [2:0]        hall_eff;
    logic [10:0]       dec;
    logic              lock_en;
    logic              all_off;
    logic              bot_ok;
    logic              drive_en;
    logic [15:0]       cap_r;

    assign pwm_tick = (pwm_cnt_r == PWM_CW'(PWM_PERIOD - 1));

    always_comb begin
        pwm_cnt_nxt  = pwm_tick ? '0 : pwm_cnt_r + PWM_CW'(1);
        hall_eff     = hall_s & {3{hall_sup_r}}; // R15
        dec          = hcp_decode(hall_eff);
        hall_sup_nxt = cmd_off_s; // R14
        // set wins: limit still present at the tick keeps bottoms blanked
        cl_latch_nxt = cl_s | (cl_latch_r & ~pwm_tick); // R6
        oc_nxt       = oc_s | (oc_r & ~oc_tif.expired); // R7
        uv_nxt       = uv_trip_s | (uv_r & ~uv_ok_s); // R8
        ot_nxt       = ot_trip_s | (ot_r & ~ot_ok_s); // R13
        lock_en      = cmd_lock_s & ~uv_r & ~ot_r; // R12
        lock_nxt     = (ldet_tif.expired & lock_en) | (lock_r & ~lrec_tif.expired); // R10
        // raw flags join the latched states so the first fault cycle already kills drive
        all_off      = ~cmd_off_s | oc_r | uv_r | ot_r | lock_r | lock_nxt | ~drive_en
                     | oc_s | uv_trip_s | ot_trip_s; // R9 R16
        bot_ok       = cmd_saw_s & pwm_s & ~cl_s & ~cl_latch_r; // R5 R6 R9
        if (all_off) begin
            arms_nxt = ARMS_OFF; // R16
        end else begin
            arms_nxt = (dec[5:0] & TOP_MASK) | (dec[5:0] & BOT_MASK & {6{bot_ok}}); // R5 R17
        end
        triple_nxt = dec[6];
        single_nxt = dec[7];
        step_nxt   = dec[10:8];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            arms_r     <= ARMS_OFF;
            step_r     <= STEP_NONE;
            triple_r   <= 1'b0;
            single_r   <= 1'b0;
            hall_sup_r <= 1'b0;
            cl_latch_r <= 1'b0;
            oc_r       <= 1'b0;
            uv_r       <= 1'b0;
            ot_r       <= 1'b0;
            lock_r     <= 1'b0;
            pwm_cnt_r  <= '0;
        end else begin
            arms_r     <= arms_nxt;
            step_r     <= step_nxt;
            triple_r   <= triple_nxt;
            single_r   <= single_nxt;
            hall_sup_r <= hall_sup_nxt;
            cl_latch_r <= cl_latch_nxt;
            oc_r       <= oc_nxt;
            uv_r       <= uv_nxt;
            ot_r       <= ot_nxt;
            lock_r     <= lock_nxt;
            pwm_cnt_r  <= pwm_cnt_nxt;
        end
    end

    // the recovery window opens once the overcurrent flag has dropped
    assign oc_tif.run   = oc_r & ~oc_s; // R7
    assign oc_tif.limit = TMR_W'(OC_RECOVER);
    assign oc_tif.step  = TMR_W'(1);
    // detect restarts on any edge of the triple pulse
    assign ldet_tif.run   = lock_en & ~lock_r & (triple_nxt == triple_r); // R10 R12
    assign ldet_tif.limit = TMR_W'(LOCK_DETECT) * TMR_W'(cap_r); // R11
    assign ldet_tif.step  = TMR_W'(LOCK_CAP_REF_PF);
    assign lrec_tif.run   = lock_r; // R10
    assign lrec_tif.limit = TMR_W'(LOCK_RECOVER) * TMR_W'(cap_r); // R11
    assign lrec_tif.step  = TMR_W'(LOCK_CAP_REF_PF);

    assign phase_u_top        = arms_r[ARM_UT];
    assign phase_u_bottom     = arms_r[ARM_UB];
    assign phase_v_top        = arms_r[ARM_VT];
    assign phase_v_bottom     = arms_r[ARM_VB];
    assign phase_w_top        = arms_r[ARM_WT];
    assign phase_w_bottom     = arms_r[ARM_WB];
    assign speed_pulse_triple = triple_r;
    assign speed_pulse_single = single_r;
    assign hall_supply_out    = hall_sup_r;

    // apb slave, zero wait states
    logic            setup_ph;
    logic            access_ph;
    logic            addr_hit;
    logic            rd_clr;
    logic [31:0]     rd_mux;
    logic [31:0]     prdata_r,  prdata_nxt;
    logic            drive_r,   drive_nxt;
    logic [EV_W-1:0] mask_r,    mask_nxt;
    logic [EV_W-1:0] sticky_r,  sticky_nxt;
    logic [15:0]     cap_nxt;
    logic            irq_r,     irq_nxt;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] faults;

    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign drive_en  = drive_r;
    assign faults    = {lock_r, ot_r, uv_r, oc_r, cl_latch_r};

    always_comb begin
        addr_hit = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_IRQ_STAT)
                || (paddr == ADDR_IRQ_MASK) || (paddr == ADDR_LOCK_CAP);
        rd_mux = 32'h0000_0000;
        case (paddr)
            ADDR_CTRL:     rd_mux[CTRL_DRIVE_BIT] = drive_r;
            ADDR_STATUS: begin
                rd_mux[ST_STEP_LSB +: 3]     = step_r;
                rd_mux[ST_FAULT_LSB +: EV_W] = faults;
                rd_mux[ST_HALL_SUP]          = hall_sup_r;
                rd_mux[ST_SPD_T]             = triple_r;
                rd_mux[ST_SPD_S]             = single_r;
            end
            ADDR_IRQ_STAT: rd_mux[EV_W-1:0] = sticky_r;
            ADDR_IRQ_MASK: rd_mux[EV_W-1:0] = mask_r;
            ADDR_LOCK_CAP: rd_mux[15:0]     = cap_r;
            default:       rd_mux = 32'h0000_0000;
        endcase
        prdata_nxt = setup_ph ? rd_mux : prdata_r;
        drive_nxt  = drive_r;
        mask_nxt   = mask_r;
        cap_nxt    = cap_r;
        if (access_ph && pwrite) begin
            case (paddr)
                ADDR_CTRL:     drive_nxt = pwdata[CTRL_DRIVE_BIT];
                ADDR_IRQ_MASK: mask_nxt  = pwdata[EV_W-1:0];
                // zero would make lock detection fire at once
                ADDR_LOCK_CAP: cap_nxt   = (pwdata[15:0] == 16'h0000) ? LOCK_CAP_MIN : pwdata[15:0];
                default:       cap_nxt   = cap_r;
            endcase
        end
        ev = {lock_nxt & ~lock_r, ot_nxt & ~ot_r, uv_nxt & ~uv_r, oc_nxt & ~oc_r,
              cl_latch_nxt & ~cl_latch_r};
        // only bits already returned are cleared, so a late event survives the read
        rd_clr     = access_ph & ~pwrite & (paddr == ADDR_IRQ_STAT);
        sticky_nxt = (sticky_r & ~(rd_clr ? prdata_r[EV_W-1:0] : '0)) | ev;
        irq_nxt    = |(sticky_nxt & mask_nxt);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prdata_r <= 32'h0000_0000;
            drive_r  <= CTRL_DRIVE_RST;
            mask_r   <= MASK_RST;
            sticky_r <= '0;
            cap_r    <= LOCK_CAP_RST;
            irq_r    <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            drive_r  <= drive_nxt;
            mask_r   <= mask_nxt;
            sticky_r <= sticky_nxt;
            cap_r    <= cap_nxt;
            irq_r    <= irq_nxt;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    assign pslverr = access_ph & ~addr_hit;
    assign irq     = irq_r;

    sequence s_oc_trip;
        $rose(oc_r);
    endsequence
    sequence s_all_dark;
        (arms_r == ARMS_OFF)[*8];
    endsequence
    sequence s_lock_trip;
        $rose(lock_r);
    endsequence

    a_phase_exclusive: assert property (!(arms_r[ARM_UT] && arms_r[ARM_UB]) && // R17
        !(arms_r[ARM_VT] && arms_r[ARM_VB]) && !(arms_r[ARM_WT] && arms_r[ARM_WB]))
        else $error("both arms of one phase on");
    a_step1_pair: assert property ((hall_eff == 3'b101) && !all_off && bot_ok |=> // R1
        (arms_r == ARMS_S1)) else $error("step 1 arm pair wrong");
    a_step4_pair: assert property ((hall_eff == 3'b010) && !all_off && bot_ok |=> // R2
        (arms_r == ARMS_S4)) else $error("step 4 arm pair wrong");
    a_equal_code: assert property ((hall_eff == 3'b111) |=> (arms_r == ARMS_OFF) // R3
        && triple_r && single_r) else $error("all-high code not handled");
    a_top_no_pwm: assert property (!all_off && !pwm_s |=> // R5
        ((arms_r & TOP_MASK) == ($past(dec[5:0]) & TOP_MASK)) && ((arms_r & BOT_MASK) == ARMS_OFF))
        else $error("pwm gating wrong");
    a_cl_blank: assert property (cl_latch_r |=> ((arms_r & BOT_MASK) == ARMS_OFF)) // R6
        else $error("bottom arm on during current limit");
    a_cl_release: assert property (cl_latch_r && pwm_tick && !cl_s |=> !cl_latch_r) // R6
        else $error("current limit not released at pwm tick");
    a_oc_recover: assert property (s_oc_trip |-> s_all_dark) // R7
        else $error("arms on during overcurrent recovery");
    a_uv_hold: assert property (uv_r && !uv_ok_s |=> uv_r && (arms_r == ARMS_OFF)) // R8
        else $error("undervoltage released early");
    a_ot_hold: assert property (ot_r && !ot_ok_s |=> ot_r && (arms_r == ARMS_OFF)) // R13
        else $error("overtemp released early");
    a_cmd_zone: assert property (!cmd_saw_s |=> ((arms_r & BOT_MASK) == ARMS_OFF)) // R9
        else $error("bottom arm on below sawtooth low");
    a_lock_dark: assert property (s_lock_trip |-> s_all_dark) // R10
        else $error("arms on during lock");
    a_lock_inhibit: assert property (!lock_r && (!cmd_lock_s || uv_r || ot_r) |=> !lock_r) // R12
        else $error("lock detected while inhibited");
    a_hall_supply: assert property (cmd_off_s |=> hall_supply_out) // R14
        else $error("hall supply not enabled");
    a_standby_pulse: assert property (!hall_supply_out |=> !speed_pulse_triple // R15
        && !speed_pulse_single) else $error("speed pulses not low in standby");
    a_irq_level: assert property (irq |-> $past(|(sticky_nxt & mask_nxt)))
        else $error("interrupt without unmasked cause");
endmodule

// ---- verif/hcp_hall_model.sv ----
// hall sensor and bridge model facing the commutation block
`timescale 1ns/1ps
module hcp_hall_model
    import hcp_pkg::*;
(
    input  wire logic       hall_supply_out,
    input  wire logic [2:0] code,
    input  wire logic [5:0] arms,
    output logic            hall_u_level,
    output logic            hall_v_level,
    output logic            hall_w_level,
    output logic            shoot
);
    // unpowered sensors sink their outputs low
    assign {hall_u_level, hall_v_level, hall_w_level} = hall_supply_out ? code : 3'h0;
    // bridge short when both arms of a phase conduct
    assign shoot = |(arms & (arms >> 1) & TOP_MASK);
endmodule

// ---- verif/hcp_commutation_top_tb_top.sv ----
// self-checking bench for the commutation and protection block
`timescale 1ns/1ps
module hcp_commutation_top_tb_top;
    import hcp_pkg::*;
    logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic        pready, pslverr, irq, sp_t, sp_s, hsup, hu, hv, hw, shoot, er, ok;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, seed = 32'h00013699;
    logic [3:0]  flt = 0;
    logic [1:0]  rec = 2'h3;
    logic        off = 1, saw = 1, lck = 0, pwm = 1;
    logic [2:0]  code = 0;
    wire  [5:0]  arms;
    int          fail_count = 0, total_checks = 0, cyc = 0;

    hcp_commutation_top #(.PWM_PERIOD(16), .OC_RECOVER(50), .LOCK_DETECT(40), .LOCK_RECOVER(100))
        hcp_commutation_top_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hall_u_level(hu), .hall_v_level(hv), .hall_w_level(hw),
        .current_limit_flag(flt[0]), .overcurrent_flag(flt[1]), .undervoltage_trip_flag(flt[2]),
        .undervoltage_recover_flag(rec[0]), .overtemp_trip_flag(flt[3]), .overtemp_recover_flag(rec[1]),
        .cmd_above_off(off), .cmd_above_sawtooth_low(saw), .cmd_above_lock_level(lck), .pwm_compare(pwm),
        .phase_u_top(arms[0]), .phase_u_bottom(arms[1]), .phase_v_top(arms[2]), .phase_v_bottom(arms[3]),
        .phase_w_top(arms[4]), .phase_w_bottom(arms[5]), .speed_pulse_triple(sp_t),
        .speed_pulse_single(sp_s), .hall_supply_out(hsup), .irq(irq));
    hcp_hall_model hcp_hall_model_inst (.hall_supply_out(hsup), .code(code), .arms(arms),
        .hall_u_level(hu), .hall_v_level(hv), .hall_w_level(hw), .shoot(shoot));

    initial forever #4 clk = ~clk;

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [5:0] exp_arms(logic [2:0] c, logic top_only);
        logic [5:0] a;
        case (c)
            3'h5: a = ARMS_S1;
            3'h4: a = ARMS_S2;
            3'h6: a = ARMS_S3;
            3'h2: a = ARMS_S4;
            3'h3: a = ARMS_S5;
            3'h1: a = ARMS_S6;
            default: a = ARMS_OFF;
        endcase
        return top_only ? (a & TOP_MASK) : a;
    endfunction
    // triple high on odd steps and all-high code; single high on steps one to three and all-high code
    function automatic logic [1:0] exp_spd(logic [2:0] c);
        logic [7:0] tri_tab;
        tri_tab = 8'he8;
        return {tri_tab[c], c[2]};
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic st(int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        er = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic see(logic [2:0] c, logic top_only);
        @(posedge clk);
        code <= c;
        st(5);
        chk("arms", 32'(exp_arms(c, top_only)), 32'(arms));
        chk("speed", 32'(exp_spd(c)), 32'({sp_t, sp_s}));
    endtask
    // trip one fault, release it, then restore the recover flags
    task automatic trip(int k);
        @(posedge clk);
        flt[k] <= 1'b1;
        rec <= 2'h0;
        st(5);
        chk("trip arms", 0, 32'(arms));
        @(posedge clk);
        flt[k] <= 1'b0;
        st(20);
        chk("held arms", 0, 32'(arms));
        @(posedge clk);
        rec <= 2'h3;
        st(45);
        chk("resume arms", 32'(ARMS_S1), 32'(arms));
        chk("irq level", 32'(k != EV_OC), 32'(irq));
        apb(1'b0, ADDR_IRQ_STAT, 0);
        chk("sticky", 32'h1 << k, rd);
        st(2);
        chk("irq cleared", 0, 32'(irq));
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(negedge clk) if (!reset) chk("shoot through", 0, 32'(shoot));
    // run is about 1300 cycles; ceiling leaves wide margin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            fail_count++;
            give_verdict();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, ADDR_CTRL, 0);
        chk("ctrl reset", 32'(CTRL_DRIVE_RST), rd);
        apb(1'b0, ADDR_LOCK_CAP, 0);
        chk("cap reset", 32'(LOCK_CAP_RST), rd);
        apb(1'b0, 12'h0f0, 0);
        chk("unmapped", 1, 32'(er));
        apb(1'b1, ADDR_IRQ_MASK, 32'h1d);
        for (int i = 0; i < 8; i++) see(i[2:0], 1'b0);
        @(posedge clk);
        pwm <= 1'b0;
        for (int i = 0; i < 8; i++) see(i[2:0], 1'b1);
        @(posedge clk);
        pwm <= 1'b1;
        saw <= 1'b0;
        see(3'h5, 1'b1);
        @(posedge clk);
        off <= 1'b0;
        st(5);
        chk("standby", 0, 32'({hsup, sp_t, sp_s, arms}));
        @(posedge clk);
        off <= 1'b1;
        saw <= 1'b1;
        see(3'h5, 1'b0);
        @(posedge clk);
        flt[0] <= 1'b1;
        st(5);
        chk("limit arms", 32'(ARMS_S1 & TOP_MASK), 32'(arms));
        @(posedge clk);
        flt[0] <= 1'b0;
        st(24);
        chk("limit release", 32'(ARMS_S1), 32'(arms));
        apb(1'b0, ADDR_IRQ_STAT, 0);
        chk("limit sticky", 1, rd);
        for (int k = 1; k < 4; k++) trip(k);
        @(posedge clk);
        lck <= 1'b1;
        st(30);
        chk("pre lock", 32'(ARMS_S1), 32'(arms));
        st(20);
        chk("locked", 0, 32'(arms));
        st(80);
        chk("lock hold", 0, 32'(arms));
        st(30);
        chk("lock resume", 32'(ARMS_S1), 32'(arms));
        @(posedge clk);
        lck <= 1'b0;
        apb(1'b1, ADDR_LOCK_CAP, 32'h7d0);
        apb(1'b0, ADDR_LOCK_CAP, 0);
        chk("cap write", 32'h7d0, rd);
        @(posedge clk);
        lck <= 1'b1;
        st(70);
        chk("slow pre lock", 32'(ARMS_S1), 32'(arms));
        st(20);
        chk("slow locked", 0, 32'(arms));
        @(posedge clk);
        lck <= 1'b0;
        st(200);
        chk("slow resume", 32'(ARMS_S1), 32'(arms));
        apb(1'b0, ADDR_IRQ_STAT, 0);
        chk("lock sticky", 32'h10, rd);
        apb(1'b1, ADDR_CTRL, 0);
        st(2);
        chk("drive off", 0, 32'(arms));
        apb(1'b1, ADDR_CTRL, 1);
        st(2);
        chk("drive on", 32'(ARMS_S1), 32'(arms));
        for (int i = 0; i < 60; i++) begin
            seed = lfsr(seed);
            @(posedge clk);
            pwm <= seed[3];
            see(seed[2:0], !seed[3]);
        end
        give_verdict();
    end
endmodule
